/* File: rtl/arfb_frame_builder.sv */
// frame builder: serialises remote command answers and trace events
// assumes the host sink takes bytes with a ready/valid handshake
`timescale 1ns/1ps
`default_nettype none
module arfb_frame_builder (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_resp_valid,
	input wire arfb_pkg::arfb_resp_t i_resp,
	output logic o_resp_ready,
	input wire logic i_trace_valid,
	input wire arfb_pkg::arfb_trace_t i_trace,
	output logic o_trace_ready,
	input wire logic i_verbose_assoc_en,
	input wire logic i_command_mode,
	output logic [7:0] o_tx_data,
	output logic o_tx_valid,
	input wire logic i_tx_ready
);
	//----------------------------------------------------------------
	// reset release
	//----------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	wire rst_n = rst_sync_reg[1];
	// two stages so release never lands near a clock edge
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) rst_sync_reg <= 2'b00;
		else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end

	//----------------------------------------------------------------
	// frame selection
	//----------------------------------------------------------------
	arfb_pkg::arfb_state_t state_reg, state_next;
	logic is_trace_reg;
	arfb_pkg::arfb_resp_t resp_reg;
	arfb_pkg::arfb_trace_t trace_reg;
	logic [4:0] idx_reg, idx_next;
	logic [7:0] sum_reg, sum_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic tx_valid_reg, resp_rdy_reg, trace_rdy_reg;

	// trace only when enabled and outside command mode
	wire trace_ok = i_verbose_assoc_en && !i_command_mode;
	// responses first: they answer a pending host request
	wire take_resp = (state_reg == arfb_pkg::ARFB_IDLE) && i_resp_valid;
	wire take_trace = (state_reg == arfb_pkg::ARFB_IDLE) && !i_resp_valid
		&& i_trace_valid && trace_ok;
	// trace events arriving while disabled are drained and dropped
	wire drop_trace = (state_reg == arfb_pkg::ARFB_IDLE) && !i_resp_valid
		&& i_trace_valid && !trace_ok;
	// frame data length: header bytes plus per-frame payload
	wire [4:0] body_len = is_trace_reg ?
		arfb_pkg::TRACE_HDR + trace_reg.data_len :
		arfb_pkg::RESP_HDR + resp_reg.data_len;
	wire [15:0] len16 = {11'h000, body_len};
	wire [15:0] n16 = resp_reg.addr16_known ? resp_reg.addr16 :
		arfb_pkg::ADDR16_UNKNOWN;
	wire [4:0] tdi = idx_reg - arfb_pkg::TRACE_HDR;
	wire [4:0] rdi = idx_reg - arfb_pkg::RESP_HDR;
	wire [7:0] trace_byte = (idx_reg == arfb_pkg::CNT_ZERO) ?
		arfb_pkg::TYPE_TRACE : (idx_reg == arfb_pkg::CNT_ONE) ?
		trace_reg.code : trace_reg.data[tdi*8 +: 8];

	// pick byte idx of the response frame data
	function automatic logic [7:0] resp_byte(input logic [4:0] i,
		input arfb_pkg::arfb_resp_t r, input logic [15:0] a16,
		input logic [4:0] di);
		logic [7:0] b;
		b = r.data[di*8 +: 8];
		if (i == arfb_pkg::CNT_ZERO) b = arfb_pkg::TYPE_RESP;
		else if (i == arfb_pkg::CNT_ONE) b = r.frame_id;
		else if (i <= arfb_pkg::RESP_ADDR_END)
			b = r.addr64[(arfb_pkg::RESP_ADDR_END - i)*8 +: 8];
		else if (i <= arfb_pkg::RESP_N16_END)
			b = (i != arfb_pkg::RESP_N16_END) ? a16[15:8] : a16[7:0];
		else if (i <= arfb_pkg::RESP_CMD_END)
			b = (i != arfb_pkg::RESP_CMD_END) ?
				r.cmd_name[15:8] : r.cmd_name[7:0];
		else if (i == arfb_pkg::RESP_STAT_POS) b = r.status;
		return b;
	endfunction

	wire [7:0] body_byte = is_trace_reg ? trace_byte :
		resp_byte(idx_reg, resp_reg, n16, rdi);
	wire accept = !tx_valid_reg || i_tx_ready;

	//----------------------------------------------------------------
	// byte sequencer
	//----------------------------------------------------------------
	// one byte per accepted handshake; checksum over frame data only
	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		sum_next = sum_reg;
		tx_data_next = tx_data_reg;
		if (accept) begin
			unique case (state_reg)
			arfb_pkg::ARFB_IDLE: begin
				if (take_resp || take_trace) begin
					state_next = arfb_pkg::ARFB_DELIM;
				end
			end
			arfb_pkg::ARFB_DELIM: begin
				tx_data_next = arfb_pkg::DELIM;
				idx_next = arfb_pkg::CNT_ZERO;
				sum_next = 8'h00;
				state_next = arfb_pkg::ARFB_LEN;
			end
			arfb_pkg::ARFB_LEN: begin
				tx_data_next = (idx_reg == arfb_pkg::CNT_ZERO) ?
					len16[15:8] : len16[7:0];
				idx_next = idx_reg + 5'h01;
				if (idx_reg == arfb_pkg::CNT_ONE) begin
					idx_next = arfb_pkg::CNT_ZERO;
					state_next = arfb_pkg::ARFB_BODY;
				end
			end
			arfb_pkg::ARFB_BODY: begin
				tx_data_next = body_byte;
				sum_next = sum_reg + body_byte;
				idx_next = idx_reg + 5'h01;
				if (idx_reg == body_len - 5'h01) begin
					state_next = arfb_pkg::ARFB_CSUM;
				end
			end
			arfb_pkg::ARFB_CSUM: begin
				tx_data_next = 8'hFF - sum_reg;
				state_next = arfb_pkg::ARFB_IDLE;
			end
			endcase
		end
	end

	// capture a frame's content on acceptance, so each answer is its own
	// frame and several answers to one request follow with at least one idle cycle between frames
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			resp_reg <= '0;
			trace_reg <= '0;
			is_trace_reg <= 1'b0;
		end else if (accept && (take_resp || take_trace)) begin
			resp_reg <= i_resp;
			trace_reg <= i_trace;
			is_trace_reg <= take_trace;
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= arfb_pkg::ARFB_IDLE;
			idx_reg <= 5'h00;
			sum_reg <= 8'h00;
			tx_data_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
			resp_rdy_reg <= 1'b0;
			trace_rdy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			sum_reg <= sum_next;
			tx_data_reg <= tx_data_next;
			if (accept) tx_valid_reg <= state_reg != arfb_pkg::ARFB_IDLE;
			resp_rdy_reg <= accept && take_resp && !resp_rdy_reg;
			trace_rdy_reg <= (accept && take_trace || drop_trace)
				&& !trace_rdy_reg;
		end
	end

	assign o_tx_data = tx_data_reg;
	assign o_tx_valid = tx_valid_reg;
	assign o_resp_ready = resp_rdy_reg;
	assign o_trace_ready = trace_rdy_reg;
endmodule
`default_nettype wire

/* File: rtl/arfb_pkg.sv */
// package for the remote response and association trace frame builder
// assumes one system clock and a byte-wide outbound serial stream
// Notes on behaviour
// - a remote command answer yields one response frame of type 0x97
// - one request may yield several response frames, e.g. node discovery
// - the request's frame identifier is copied unchanged into the response
// - the responder's 64-bit address follows the identifier, high byte first
// - 16-bit network address next; 0xFFFE when it is unknown
// - the two-character command name follows the 16-bit address
// - status byte: 0 ok, 1 error, 2 bad command, 3 bad parameter, 4 failed
// - queried value bytes follow status; writes carry no value bytes
// - association trace frames go out only while the verbose option is on
// - trace frames are suppressed while command mode is active
// - trace frame is type 0x98 followed by one status code byte
// - trace data length varies per event; length field sized per frame
package arfb_pkg;
	localparam logic [7:0] DELIM = 8'h7E;
	localparam logic [7:0] TYPE_RESP = 8'h97;
	localparam logic [7:0] TYPE_TRACE = 8'h98;
	localparam logic [15:0] ADDR16_UNKNOWN = 16'hFFFE;
	localparam int DATA_MAX = 16;
	localparam logic [4:0] DATA_MAX_W = 5'h10;
	localparam logic [4:0] RESP_HDR = 5'h0F;
	localparam logic [4:0] TRACE_HDR = 5'h02;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	localparam logic [4:0] CNT_ONE = 5'h01;
	localparam logic [4:0] RESP_ADDR_END = 5'h09;
	localparam logic [4:0] RESP_N16_END = 5'h0B;
	localparam logic [4:0] RESP_CMD_END = 5'h0D;
	localparam logic [4:0] RESP_STAT_POS = 5'h0E;

	// command outcome codes
	typedef enum logic [7:0] {
		ARFB_ST_OK = 8'h00,
		ARFB_ST_ERROR = 8'h01,
		ARFB_ST_BAD_CMD = 8'h02,
		ARFB_ST_BAD_PARAM = 8'h03,
		ARFB_ST_TX_FAIL = 8'h04
	} arfb_status_t;

	// remote command answer as delivered by the network side
	typedef struct packed {
		logic [7:0] frame_id;
		logic [63:0] addr64;
		logic addr16_known;
		logic [15:0] addr16;
		logic [15:0] cmd_name;
		arfb_status_t status;
		logic [4:0] data_len;
		logic [DATA_MAX*8-1:0] data;
	} arfb_resp_t;

	// association trace event
	typedef struct packed {
		logic [7:0] code;
		logic [4:0] data_len;
		logic [DATA_MAX*8-1:0] data;
	} arfb_trace_t;

	typedef enum logic [4:0] {
		ARFB_IDLE = 5'b00001,
		ARFB_DELIM = 5'b00010,
		ARFB_LEN = 5'b00100,
		ARFB_BODY = 5'b01000,
		ARFB_CSUM = 5'b10000
	} arfb_state_t;
endpackage

/* File: bench/arfb_frame_builder_asserts.sv */
// stream checks for the frame builder
// assumes it is bound to arfb_frame_builder and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module arfb_frame_builder_asserts (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic o_resp_ready,
	input wire logic o_trace_ready,
	input wire logic i_verbose_assoc_en,
	input wire logic i_command_mode,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_valid,
	input wire logic i_tx_ready
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	logic [7:0] pos_reg, len_reg, sum_reg;
	logic kind_reg;
	wire acc = o_tx_valid && i_tx_ready;
	// byte position since the take; len parked high so no early match
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pos_reg <= 8'h00;
			len_reg <= 8'hF0;
			sum_reg <= 8'h00;
			kind_reg <= 1'b0;
		end else if (o_resp_ready || o_trace_ready) begin
			pos_reg <= 8'h00;
			len_reg <= 8'hF0;
			sum_reg <= 8'h00;
			kind_reg <= o_resp_ready;
		end else if (acc) begin
			pos_reg <= pos_reg + 8'h01;
			if (pos_reg == 8'h02)
				len_reg <= o_tx_data;
			if (pos_reg > 8'h02)
				sum_reg <= sum_reg + o_tx_data;
		end
	end
	sequence s_delim;
		o_tx_valid && o_tx_data == arfb_pkg::DELIM;
	endsequence
	a_hold_byte: assert property (o_tx_valid && !i_tx_ready |=>
		o_tx_valid && $stable(o_tx_data)) else $error("byte not held");
	a_frame_start: assert property (o_resp_ready |=> s_delim)
		else $error("no delimiter after take");
	a_resp_pulse: assert property (o_resp_ready |=> !o_resp_ready)
		else $error("response ready too long");
	a_ready_excl: assert property (!(o_resp_ready && o_trace_ready))
		else $error("two takes at once");
	a_frame_type: assert property (o_tx_valid && pos_reg == 8'h03 |->
		o_tx_data == (kind_reg ? 8'h97 : 8'h98)) else $error("bad type");
	a_len_high: assert property (o_tx_valid && pos_reg == 8'h01 |->
		o_tx_data == 8'h00) else $error("bad length high byte");
	a_csum_byte: assert property (o_tx_valid && pos_reg == len_reg + 8'h03
		|-> o_tx_data == 8'hFF - sum_reg) else $error("bad checksum");
	a_trace_drop: assert property (o_trace_ready &&
		($past(i_command_mode) || !$past(i_verbose_assoc_en)) |=> !o_tx_valid)
		else $error("suppressed trace sent");
endmodule
`default_nettype wire

/* File: bench/arfb_host_sink.sv */
// host model reading the outbound byte stream
// assumes the bench reads the captured queue q by hierarchy
`timescale 1ns/1ps
`default_nettype none
module arfb_host_sink (
	input wire logic i_mclk,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	output logic o_ready
);
	logic [7:0] q[$];
	logic tog_reg = 1'b0;
	initial o_ready = 1'b0;
	// slow mode stalls every other cycle so bytes must be held
	always @(posedge i_mclk) begin
		if (i_valid && o_ready)
			q.push_back(i_data);
		tog_reg <= !tog_reg;
		o_ready <= !i_slow || tog_reg;
	end
endmodule
`default_nettype wire

/* File: bench/arfb_frame_builder_bench.sv */
// self-checking bench for the frame builder
// assumes the host sink model and the stream checker beside it
`timescale 1ns/1ps
`default_nettype none
module arfb_frame_builder_bench;
	localparam logic [127:0] PAT = 128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0;
	logic i_mclk, i_rst_n, rv, tv, ven, cmd, slow, rdy, txv, rrdy, trdy;
	logic [7:0] txd;
	arfb_pkg::arfb_resp_t resp;
	arfb_pkg::arfb_trace_t tr;
	int bad_count, total_checks;
	initial begin
		i_mclk = 1'b0;
		forever #4 i_mclk = ~i_mclk;
	end
	arfb_frame_builder arfb_frame_builder_i (.i_mclk(i_mclk),
		.i_rst_n(i_rst_n), .i_resp_valid(rv), .i_resp(resp),
		.o_resp_ready(rrdy), .i_trace_valid(tv), .i_trace(tr),
		.o_trace_ready(trdy), .i_verbose_assoc_en(ven),
		.i_command_mode(cmd), .o_tx_data(txd), .o_tx_valid(txv),
		.i_tx_ready(rdy));
	arfb_host_sink arfb_host_sink_i (.i_mclk(i_mclk), .i_slow(slow),
		.i_valid(txv), .i_data(txd), .o_ready(rdy));
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	// wraps frame data and compares it with what the host captured
	task get_frame(input logic [7:0] d[$]);
		logic [7:0] f[$];
		logic [7:0] s;
		s = 8'h00;
		foreach (d[i]) s += d[i];
		f = {8'h7E, 8'h00, 8'(d.size()), d, 8'hFF - s};
		for (int k = 0; k < 900 && arfb_host_sink_i.q.size() < f.size(); k++)
			@(negedge i_mclk);
		chk("byte count", 8'(f.size()), 8'(arfb_host_sink_i.q.size()));
		while (f.size() > 0 && arfb_host_sink_i.q.size() > 0)
			chk("frame byte", f.pop_front(), arfb_host_sink_i.q.pop_front());
	endtask
	// odd codes know the short address; codes 2 and 3 use a stalling host
	task send_resp(input logic [2:0] st);
		logic [7:0] d[$];
		resp = '{8'h50 + 8'(st), 64'h0013A20040522BAA, st[0], 16'h7D84,
			16'h534C, arfb_pkg::arfb_status_t'(8'(st)), 5'(st * 4), PAT};
		slow = st[1];
		rv = 1'b1;
		for (int k = 0; k < 200 && !rrdy; k++) @(negedge i_mclk);
		chk("response taken", 8'h01, 8'(rrdy));
		rv = 1'b0;
		d = {8'h97, resp.frame_id};
		for (int k = 7; k >= 0; k--) d.push_back(resp.addr64[k*8+:8]);
		// queue items are single bytes, so the short address goes in two
		d = {d, st[0] ? 8'h7D : 8'hFF, st[0] ? 8'h84 : 8'hFE,
			8'h53, 8'h4C, 8'(st)};
		for (int k = 0; k < st * 4; k++) d.push_back(PAT[k*8+:8]);
		get_frame(d);
	endtask
	// a trace goes out only when enabled and outside command mode
	task send_trace(input logic en, input logic cm, input logic [4:0] n);
		logic [7:0] d[$];
		ven = en;
		cmd = cm;
		tr = '{8'h02 + 8'(n), n, PAT};
		tv = 1'b1;
		for (int k = 0; k < 200 && !trdy; k++) @(negedge i_mclk);
		chk("trace taken", 8'h01, 8'(trdy));
		tv = 1'b0;
		d = {8'h98, tr.code};
		for (int k = 0; k < n; k++) d.push_back(PAT[k*8+:8]);
		if (en && !cm) begin
			get_frame(d);
		end else begin
			repeat (6) @(negedge i_mclk);
			chk("dropped trace", 8'h00, 8'(arfb_host_sink_i.q.size()));
		end
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{i_rst_n, rv, tv, ven, cmd, slow} = 6'h00;
		resp = '0;
		tr = '0;
		repeat (2) @(negedge i_mclk);
		i_rst_n = 1'b1;
		repeat (3) @(negedge i_mclk);
		for (int s = 0; s < 5; s++) send_resp(3'(s));
		send_trace(1'b1, 1'b0, 5'h0B);
		send_trace(1'b1, 1'b1, 5'h02);
		send_trace(1'b0, 1'b0, 5'h01);
		finish_test();
	end
	// generous bound: each frame needs well under a hundred cycles
	initial begin
		repeat (20000) @(posedge i_mclk);
		bad_count++;
		finish_test();
	end
endmodule
bind arfb_frame_builder arfb_frame_builder_asserts
	arfb_frame_builder_asserts_i (.*);
`default_nettype wire
